//--- phgpio_pkg.sv
package phgpio_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] OFF_PIN_DIRECTION_H = 2'h0;
    localparam logic [1:0] OFF_PIN_LEVEL_H = 2'h1;
    localparam logic [1:0] OFF_OUTPUT_LATCH_H = 2'h2;
    localparam logic [1:0] OFF_ANALOG_PIN_CONFIG = 2'h3;
    // Reset values
    localparam logic [7:0] RST_PIN_DIRECTION_H = 8'hFF;
    localparam logic [7:0] RST_OUTPUT_LATCH_H = 8'h00;
    localparam logic [7:0] RST_ANALOG_PIN_CONFIG = 8'h00;
    // Analog config layout: bits 7:6 unimplemented, read as zero
    localparam int ANA_CFG_WIDTH = 6;
    localparam int ANA_SEL_BIT3_POS = 3;
    // Pin groups
    localparam int EXT_ADDR_LO_PIN = 0;
    localparam int EXT_ADDR_PINS = 4;
    localparam int ANALOG_LO_PIN = 4;
endpackage

//--- phgpio_port.sv
`timescale 1ns/1ps
module phgpio_port #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] analog_en,
    input wire logic ext_mem_en,
    input wire logic [3:0] ext_addr_hi,
    input wire logic pwm_pin_remap,
    input wire logic pwm_unit3_out_c,
    input wire logic pwm_unit3_out_b,
    input wire logic pwm_unit1_out_c,
    input wire logic pwm_unit1_out_b,
    input wire logic [3:0] pwm_out_en,
    input wire logic [3:0] pwm_shutdown_tristate
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [WIDTH-1:0] dir;
        logic [WIDTH-1:0] lat;
        logic [phgpio_pkg::ANA_CFG_WIDTH-1:0] acfg;
        logic [WIDTH-1:0] sync1;
        logic [WIDTH-1:0] sync2;
        logic [7:0] rdata;
    } phgpio_state_t;

    phgpio_state_t st_r;
    phgpio_state_t st_nxt;
    logic [WIDTH-1:0] pin_out_c;
    logic [WIDTH-1:0] pin_oe_c;
    logic [3:0] pwm_val;
    logic analog_on;

    assign pwm_val = {pwm_unit1_out_b, pwm_unit1_out_c, pwm_unit3_out_b, pwm_unit3_out_c};
    // Analog select bit 3 clear keeps the high pins set as inputs analog, matching the reset default
    assign analog_on = ~st_r.acfg[phgpio_pkg::ANA_SEL_BIT3_POS];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        // Pins cross into the clock domain through two flops
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.rdata = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                phgpio_pkg::OFF_PIN_DIRECTION_H: st_nxt.dir = reg_wdata[WIDTH-1:0];
                phgpio_pkg::OFF_PIN_LEVEL_H: st_nxt.lat = reg_wdata[WIDTH-1:0];
                phgpio_pkg::OFF_OUTPUT_LATCH_H: st_nxt.lat = reg_wdata[WIDTH-1:0];
                phgpio_pkg::OFF_ANALOG_PIN_CONFIG: begin
                    st_nxt.acfg = reg_wdata[phgpio_pkg::ANA_CFG_WIDTH-1:0];
                end
                default: st_nxt.lat = st_r.lat;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                phgpio_pkg::OFF_PIN_DIRECTION_H: st_nxt.rdata = 8'(st_r.dir);
                phgpio_pkg::OFF_PIN_LEVEL_H: st_nxt.rdata = 8'(st_r.sync2);
                phgpio_pkg::OFF_OUTPUT_LATCH_H: st_nxt.rdata = 8'(st_r.lat);
                phgpio_pkg::OFF_ANALOG_PIN_CONFIG: st_nxt.rdata = 8'(st_r.acfg);
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.dir <= phgpio_pkg::RST_PIN_DIRECTION_H;
            st_r.lat <= phgpio_pkg::RST_OUTPUT_LATCH_H;
            st_r.acfg <= 6'(phgpio_pkg::RST_ANALOG_PIN_CONFIG);
            st_r.sync1 <= '0;
            st_r.sync2 <= '0;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin muxing is combinational so overrides reach the pad in the same cycle
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        always_comb begin
            pin_out_c[i] = st_r.lat[i];
            pin_oe_c[i] = ~st_r.dir[i];
            if (i < phgpio_pkg::EXT_ADDR_PINS) begin
                if (ext_mem_en) begin
                    pin_out_c[i] = ext_addr_hi[i % 4];
                    pin_oe_c[i] = 1'b1;
                end
            end else if (!pwm_pin_remap && !st_r.dir[i] && pwm_out_en[i % 4]) begin
                pin_out_c[i] = pwm_val[i % 4];
                pin_oe_c[i] = ~pwm_shutdown_tristate[i % 4];
            end
        end
        if (i >= phgpio_pkg::ANALOG_LO_PIN) begin : g_ana
            assign analog_en[i] = analog_on & st_r.dir[i];
        end else begin : g_dig
            assign analog_en[i] = 1'b0;
        end
    end

    assign pin_out = pin_out_c;
    assign pin_oe = pin_oe_c;
    assign reg_rdata = st_r.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    property p_reset_inputs;
        @(posedge core_clk) $rose(reset_n) |-> (pin_oe == '0 || ext_mem_en);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset");

    property p_dir_out;
        @(posedge core_clk) disable iff (!reset_n)
        (!ext_mem_en && !st_r.dir[0]) |-> (pin_oe[0] && pin_out[0] == st_r.lat[0]);
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("output pin not from latch");

    property p_dir_in;
        @(posedge core_clk) disable iff (!reset_n)
        (!ext_mem_en && st_r.dir[1]) |-> !pin_oe[1];
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("input pin driven");

    property p_lat_rmw;
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == phgpio_pkg::OFF_OUTPUT_LATCH_H) ##1
        (reg_rd && reg_addr == phgpio_pkg::OFF_OUTPUT_LATCH_H && !reg_wr)
        |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_lat_rmw: assert property (p_lat_rmw) else $error("latch readback wrong");

    property p_port_read;
        @(posedge core_clk) disable iff (!reset_n)
        (reg_rd && reg_addr == phgpio_pkg::OFF_PIN_LEVEL_H) |=> reg_rdata == $past(pin_in, 3);
    endproperty
    a_port_read: assert property (p_port_read) else $error("port read not pin level");

    property p_ext_addr;
        @(posedge core_clk) disable iff (!reset_n)
        ext_mem_en |-> (pin_oe[3:0] == 4'hF && pin_out[3:0] == ext_addr_hi);
    endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("address lines not driven");

    property p_pwm_map;
        @(posedge core_clk) disable iff (!reset_n)
        (!pwm_pin_remap && !st_r.dir[7] && pwm_out_en[3]) |-> pin_out[7] == pwm_unit1_out_b;
    endproperty
    a_pwm_map: assert property (p_pwm_map) else $error("pwm 1b not on pin 7");

    property p_remap;
        @(posedge core_clk) disable iff (!reset_n)
        (pwm_pin_remap && !st_r.dir[4]) |-> pin_out[4] == st_r.lat[4];
    endproperty
    a_remap: assert property (p_remap) else $error("pwm mapped while remapped");

    property p_shutdown;
        @(posedge core_clk) disable iff (!reset_n)
        (!pwm_pin_remap && !st_r.dir[5] && pwm_out_en[1] && pwm_shutdown_tristate[1])
        |-> !pin_oe[5];
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("pwm not tristated");

    ////////////////////////////////////////////////////////////////////////////////
    // Reset leaves every pin set as input and the high pins analog
    property p_reset_state;
        @(posedge core_clk) $rose(reset_n) |->
        (st_r.dir == phgpio_pkg::RST_PIN_DIRECTION_H &&
         st_r.lat == phgpio_pkg::RST_OUTPUT_LATCH_H);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state not reset");

    property p_analog_default;
        @(posedge core_clk) $rose(reset_n) |-> analog_en[7:4] == 4'hF;
    endproperty
    a_analog_default: assert property (p_analog_default) else $error("reset not analog");

    property p_analog_low;
        @(posedge core_clk) disable iff (!reset_n)
        analog_en[3:0] == 4'h0;
    endproperty
    a_analog_low: assert property (p_analog_low) else $error("low pins analog");

    property p_analog_off;
        @(posedge core_clk) disable iff (!reset_n)
        st_r.acfg[phgpio_pkg::ANA_SEL_BIT3_POS] |-> analog_en == '0;
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog not off");

    property p_analog_output;
        @(posedge core_clk) disable iff (!reset_n)
        !st_r.dir[4] |-> !analog_en[4];
    endproperty
    a_analog_output: assert property (p_analog_output) else $error("output is analog");

    // Register writes land one cycle later and nothing else moves the state
    property p_dir_write;
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == phgpio_pkg::OFF_PIN_DIRECTION_H) |=> st_r.dir == $past(reg_wdata);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("dir write lost");

    property p_dir_hold;
        @(posedge core_clk) disable iff (!reset_n)
        !(reg_wr && reg_addr == phgpio_pkg::OFF_PIN_DIRECTION_H) |=> $stable(st_r.dir);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("dir changed unasked");

    property p_lat_write;
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == phgpio_pkg::OFF_OUTPUT_LATCH_H) |=> st_r.lat == $past(reg_wdata);
    endproperty
    a_lat_write: assert property (p_lat_write) else $error("latch write lost");

    property p_port_write;
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == phgpio_pkg::OFF_PIN_LEVEL_H) |=> st_r.lat == $past(reg_wdata);
    endproperty
    a_port_write: assert property (p_port_write) else $error("port write missed");

    property p_lat_hold;
        @(posedge core_clk) disable iff (!reset_n)
        !(reg_wr && (reg_addr == phgpio_pkg::OFF_PIN_LEVEL_H ||
            reg_addr == phgpio_pkg::OFF_OUTPUT_LATCH_H)) |=> $stable(st_r.lat);
    endproperty
    a_lat_hold: assert property (p_lat_hold) else $error("latch changed unasked");

    property p_acfg_write;
        @(posedge core_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == phgpio_pkg::OFF_ANALOG_PIN_CONFIG)
        |=> st_r.acfg == $past(reg_wdata[phgpio_pkg::ANA_CFG_WIDTH-1:0]);
    endproperty
    a_acfg_write: assert property (p_acfg_write) else $error("analog config lost");

    property p_ext_high_free;
        @(posedge core_clk) disable iff (!reset_n)
        (ext_mem_en && pwm_out_en == 4'h0) |-> pin_oe[7:4] == ~st_r.dir[7:4];
    endproperty
    a_ext_high_free: assert property (p_ext_high_free) else $error("high pins moved");

    property p_pwm_all;
        @(posedge core_clk) disable iff (!reset_n)
        (!pwm_pin_remap && pwm_out_en == 4'hF && st_r.dir[7:4] == 4'h0) |->
        pin_out[7:4] == {pwm_unit1_out_b, pwm_unit1_out_c, pwm_unit3_out_b, pwm_unit3_out_c};
    endproperty
    a_pwm_all: assert property (p_pwm_all) else $error("pwm on wrong pins");

    property p_remap_oe;
        @(posedge core_clk) disable iff (!reset_n)
        (pwm_pin_remap && !st_r.dir[6]) |-> (pin_oe[6] && pin_out[6] == st_r.lat[6]);
    endproperty
    a_remap_oe: assert property (p_remap_oe) else $error("remapped pin not port data");

    property p_shutdown_off;
        @(posedge core_clk) disable iff (!reset_n)
        (!pwm_pin_remap && !st_r.dir[6] && pwm_out_en[2] && !pwm_shutdown_tristate[2])
        |-> (pin_oe[6] && pin_out[6] == pwm_unit1_out_c);
    endproperty
    a_shutdown_off: assert property (p_shutdown_off) else $error("pwm not driven");

    // One pair per pin; only the memory interface may drive a pin set as input
    for (genvar k = 0; k < WIDTH; k++) begin : g_pin_chk
        property p_pin_released;
            @(posedge core_clk) disable iff (!reset_n)
            (st_r.dir[k] && !(k < phgpio_pkg::EXT_ADDR_PINS && ext_mem_en)) |-> !pin_oe[k];
        endproperty
        a_pin_released: assert property (p_pin_released) else $error("input driven");

        property p_pin_driven;
            @(posedge core_clk) disable iff (!reset_n)
            (!st_r.dir[k] && !ext_mem_en && pwm_out_en == 4'h0)
            |-> (pin_oe[k] && pin_out[k] == st_r.lat[k]);
        endproperty
        a_pin_driven: assert property (p_pin_driven) else $error("output not latch");
    end

    c_ext: cover property (@(posedge core_clk) disable iff (!reset_n) ext_mem_en);
    c_pwm: cover property (@(posedge core_clk) disable iff (!reset_n)
        !pwm_pin_remap && pwm_out_en[0] && !st_r.dir[4]);
    c_port_rd: cover property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd && reg_addr == phgpio_pkg::OFF_PIN_LEVEL_H);
    c_remap: cover property (@(posedge core_clk) disable iff (!reset_n)
        pwm_pin_remap && !st_r.dir[4]);
    c_shutdown: cover property (@(posedge core_clk) disable iff (!reset_n)
        pwm_shutdown_tristate[0] && pwm_out_en[0] && !st_r.dir[4]);
endmodule

//--- phgpio_pad_model.sv
`timescale 1ns/1ps
// Pad ring: a released pin follows the outside driver, so no pin floats
module phgpio_pad_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_drive,
    output logic [7:0] pin_in
);
    assign pin_in = (pin_out & pin_oe) | (ext_drive & ~pin_oe);
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, rd_val, reg_rdata, pin_in, pin_out, pin_oe, analog_en;
    logic [7:0] ext_drive = 8'h36;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ext_mem_en = 1'b0, pwm_pin_remap = 1'b0;
    logic [3:0] ext_addr_hi = 4'h0, pwm_lvl = 4'h0, pwm_out_en = 4'h0;
    logic [3:0] pwm_shutdown_tristate = 4'h0;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #20 core_clk = ~core_clk;
    phgpio_port i_phgpio_port (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .analog_en(analog_en),
        .ext_mem_en(ext_mem_en), .ext_addr_hi(ext_addr_hi), .pwm_pin_remap(pwm_pin_remap),
        .pwm_unit3_out_c(pwm_lvl[0]), .pwm_unit3_out_b(pwm_lvl[1]),
        .pwm_unit1_out_c(pwm_lvl[2]), .pwm_unit1_out_b(pwm_lvl[3]),
        .pwm_out_en(pwm_out_en), .pwm_shutdown_tristate(pwm_shutdown_tristate));
    phgpio_pad_model i_phgpio_pad_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_drive(ext_drive), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic t_reset;
        rd(phgpio_pkg::OFF_PIN_DIRECTION_H);
        chk(rd_val, phgpio_pkg::RST_PIN_DIRECTION_H);
        rd(phgpio_pkg::OFF_OUTPUT_LATCH_H);
        chk(rd_val, phgpio_pkg::RST_OUTPUT_LATCH_H);
        chk(pin_oe, 8'h00);
        chk(analog_en, 8'hF0);
        $display("reset test done");
    endtask
    task automatic t_port;
        wr(phgpio_pkg::OFF_OUTPUT_LATCH_H, 8'hA5);
        wr(phgpio_pkg::OFF_PIN_DIRECTION_H, 8'h0F);
        chk(pin_oe, 8'hF0);
        chk(pin_out & pin_oe, 8'hA0);
        // Two sync flops on the pads before the port read sees them
        repeat (3) @(posedge core_clk);
        rd(phgpio_pkg::OFF_PIN_LEVEL_H);
        chk(rd_val, 8'hA6);
        rd(phgpio_pkg::OFF_OUTPUT_LATCH_H);
        chk(rd_val, 8'hA5);
        wr(phgpio_pkg::OFF_PIN_LEVEL_H, 8'h3C);
        chk(pin_out & pin_oe, 8'h30);
        $display("port test done");
    endtask
    task automatic t_ext;
        @(posedge core_clk);
        ext_mem_en <= 1'b1;
        ext_addr_hi <= 4'h9;
        #1;
        chk({4'h0, pin_oe[3:0]}, 8'h0F);
        chk({4'h0, pin_out[3:0]}, 8'h09);
        @(posedge core_clk);
        ext_mem_en <= 1'b0;
        #1;
        chk({4'h0, pin_oe[3:0]}, 8'h00);
        $display("ext memory test done");
    endtask
    task automatic t_pwm;
        wr(phgpio_pkg::OFF_PIN_DIRECTION_H, 8'h00);
        @(posedge core_clk);
        pwm_out_en <= 4'hF;
        pwm_lvl <= 4'h5;
        #1;
        chk({4'h0, pin_out[7:4]}, 8'h05);
        @(posedge core_clk);
        pwm_pin_remap <= 1'b1;
        #1;
        chk({4'h0, pin_out[7:4]}, 8'h03);
        @(posedge core_clk);
        pwm_pin_remap <= 1'b0;
        pwm_shutdown_tristate <= 4'hF;
        #1;
        chk({4'h0, pin_oe[7:4]}, 8'h00);
        $display("pwm test done");
    endtask
    // Write then read the latch with no gap while the pins show something else
    task automatic t_rmw;
        @(posedge core_clk);
        reg_addr <= phgpio_pkg::OFF_OUTPUT_LATCH_H;
        reg_wdata <= 8'h3A;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, 8'h3A);
        repeat (2) @(posedge core_clk);
        rd(phgpio_pkg::OFF_PIN_LEVEL_H);
        chk(rd_val, 8'h36);
        $display("latch readback test done");
    endtask
    task automatic t_analog;
        wr(phgpio_pkg::OFF_PIN_DIRECTION_H, 8'hFF);
        wr(phgpio_pkg::OFF_ANALOG_PIN_CONFIG, 8'hF7);
        chk(analog_en, 8'hF0);
        rd(phgpio_pkg::OFF_ANALOG_PIN_CONFIG);
        chk(rd_val, 8'h37);
        wr(phgpio_pkg::OFF_ANALOG_PIN_CONFIG, 8'h08);
        chk(analog_en, 8'h00);
        $display("analog config test done");
    endtask
    task automatic t_rst_mid;
        wr(phgpio_pkg::OFF_OUTPUT_LATCH_H, 8'h77);
        wr(phgpio_pkg::OFF_PIN_DIRECTION_H, 8'h00);
        @(posedge core_clk);
        reset_n <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(pin_oe, 8'h00);
        chk(analog_en, 8'hF0);
        @(posedge core_clk);
        reset_n <= 1'b1;
        rd(phgpio_pkg::OFF_PIN_DIRECTION_H);
        chk(rd_val, phgpio_pkg::RST_PIN_DIRECTION_H);
        rd(phgpio_pkg::OFF_OUTPUT_LATCH_H);
        chk(rd_val, phgpio_pkg::RST_OUTPUT_LATCH_H);
        $display("mid-run reset test done");
    endtask
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
        t_port();
        t_rmw();
        t_ext();
        t_pwm();
        t_analog();
        t_rst_mid();
        test_done();
    end
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end
endmodule
